// file: accel_power_selftest_fifo_regs.v
// upper register bank: bandwidth, power control, self test, soft reset, queue read port
//
// How it works
// RULE_01: bandwidth field codes 000 and 001 pick 160 Hz and 320 Hz.
// RULE_02: codes 010, 011, 100 pick 640, 1280, 2560 Hz.
// RULE_03: power control at 0x3F, resets to 0x00: standby, filters on.
// RULE_04: power control bit 7 set selects fast serial mode.
// RULE_05: power control bit 5 picks low or high wake level.
// RULE_06: settling select 0 waits 462.5 ms before data valid.
// RULE_07: settling select 1 waits four output-data-rate periods.
// RULE_08: bit 3 set bypasses the low-pass filter.
// RULE_09: bit 2 set bypasses the high-pass filter.
// RULE_10: mode 11 measure, 10 instant-on, 01 wake-up, 00 standby.
// RULE_11: writing 1 to bit 0 at 0x40 runs self test.
// RULE_12: writing 0 ends self test; bit 1 reports finished.
// RULE_13: writing 0x52 to 0x41 fully resets the device.
// RULE_14: direct read at 0x42 pops one two-byte word.
// RULE_15: popped word goes out as two bytes, high byte first.
// RULE_16: continued reads at 0x42 pop a new word every third read.
// RULE_17: bursts starting at 0x42 keep the address pointer fixed.
// RULE_18: reaching 0x42 by auto-increment does not pop.
// RULE_19: auto-incremented read of 0x42 returns zero and moves on.
// RULE_20: other writes to reset register ignored; reserved bits read zero.
`timescale 1ns/1ps
`include "accel_regs_map.vh"
module accel_power_selftest_fifo_regs #(
	parameter SETTLE_LONG_CYCLES = `SETTLE_LONG_CYCLES
) (
	input  wire        mclk,
	input  wire        reset,
	input  wire        odr_tick,
	input  wire        sample_push,
	input  wire [15:0] sample_data,
	input  wire        acc_start,
	input  wire [7:0]  acc_addr,
	input  wire        acc_wr,
	input  wire [7:0]  acc_wdata,
	input  wire        acc_rd,
	output reg  [7:0]  acc_rdata,
	output reg  [7:0]  acc_addr_ptr,
	output reg  [2:0]  bandwidth_code,
	output reg  [11:0] bandwidth_hz,
	output reg  [1:0]  op_mode,
	output reg         measure_active,
	output reg         instant_on_active,
	output reg         wakeup_active,
	output reg         fast_serial_select,
	output reg         wake_level_select,
	output reg         lowpass_bypass,
	output reg         highpass_bypass,
	output reg         data_valid,
	output reg         selfcheck_run,
	output reg         device_reset
);
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_RUN   = 3'b010;
	localparam [2:0] SELFCHECK_FINISHED  = 3'b100;

	reg  [7:0]  measure_reg;
	reg  [7:0]  power_control_reg;
	reg  [2:0]  st_state_reg;
	reg  [7:0]  st_count_reg;
	reg         st_finished_reg;
	reg  [31:0] settle_count_reg;
	reg  [2:0]  odr_count_reg;
	reg  [1:0]  byte_phase_reg;
	reg         burst_direct_reg;
	reg  [15:0] word_hold_reg;
	reg         first_access_reg;
	reg         soft_reset_reg;
	reg  [7:0]  rdata_next;
	reg         pop_next;

	wire        rst_all;
	wire [15:0] head_data;
	wire        queue_empty;
	wire        mode_change;
	wire        at_queue;

	assign rst_all  = reset | soft_reset_reg; // [RULE_13]
	assign at_queue = (acc_addr_ptr == `ADDR_QUEUE_READ);
	assign mode_change = acc_wr && acc_addr_ptr == `ADDR_POWER_CONTROL;

	function [11:0] bw_hz;
		input [2:0] code;
		begin
			case (code)
				`BW_160:  bw_hz = 12'd160;  // [RULE_01]
				`BW_320:  bw_hz = 12'd320;  // [RULE_01]
				`BW_640:  bw_hz = 12'd640;  // [RULE_02]
				`BW_1280: bw_hz = 12'd1280; // [RULE_02]
				`BW_2560: bw_hz = 12'd2560; // [RULE_02]
				default:  bw_hz = 12'd160;
			endcase
		end
	endfunction

	sample_queue u_queue (
		.mclk      (mclk),
		.reset     (rst_all),
		.push      (sample_push),
		.push_data (sample_data),
		.pop       (pop_next),
		.head_data (head_data),
		.empty     (queue_empty)
	);

	// address pointer: load on start, step after each byte except at the queue port in a burst that started there
	always @(posedge mclk) begin
		if (rst_all) begin
			acc_addr_ptr     <= 8'h00;
			first_access_reg <= 1'b0;
			burst_direct_reg <= 1'b0;
		end else if (acc_start) begin
			acc_addr_ptr     <= acc_addr;
			first_access_reg <= 1'b1;
			burst_direct_reg <= (acc_addr == `ADDR_QUEUE_READ);
		end else if (acc_rd || acc_wr) begin
			first_access_reg <= 1'b0;
			if (!(at_queue && burst_direct_reg)) // [RULE_17]
				acc_addr_ptr <= acc_addr_ptr + 8'h01; // [RULE_19]
		end
	end

	// read mux and pop decision
	always @* begin
		rdata_next = 8'h00;
		pop_next   = 1'b0;
		case (acc_addr_ptr)
			`ADDR_MEASURE:       rdata_next = measure_reg;
			`ADDR_POWER_CONTROL: rdata_next = power_control_reg & `PC_WRITE_MASK; // [RULE_20]
			`ADDR_SELFCHECK:     rdata_next = {6'h00, st_finished_reg,
				power_control_reg[0] & 1'b0 | selfcheck_run}; // [RULE_20]
			`ADDR_QUEUE_READ: begin
				if (burst_direct_reg) begin
					if (byte_phase_reg == 2'd1)
						rdata_next = word_hold_reg[15:8]; // [RULE_15]
					else if (byte_phase_reg == 2'd2)
						rdata_next = word_hold_reg[7:0]; // [RULE_15]
					else
						rdata_next = 8'h00;
					pop_next = acc_rd && (byte_phase_reg == 2'd0); // [RULE_14] [RULE_16]
				end else begin
					rdata_next = 8'h00; // [RULE_18] [RULE_19]
				end
			end
			default:             rdata_next = 8'h00;
		endcase
	end

	// byte phase of the queue port: pop, high byte, low byte, then pop again
	always @(posedge mclk) begin
		if (rst_all || acc_start) begin
			byte_phase_reg <= 2'd0;
			word_hold_reg  <= 16'h0000;
			acc_rdata      <= 8'h00;
		end else if (acc_rd) begin
			acc_rdata <= rdata_next;
			if (at_queue && burst_direct_reg) begin
				if (byte_phase_reg == 2'd2)
					byte_phase_reg <= 2'd0; // [RULE_16]
				else
					byte_phase_reg <= byte_phase_reg + 2'd1;
			end
		end else if (byte_phase_reg == 2'd1 && !acc_rd) begin
			word_hold_reg <= head_data;
		end
	end

	// writable registers
	always @(posedge mclk) begin
		if (rst_all) begin
			measure_reg       <= `RST_MEASURE;
			power_control_reg <= `RST_POWER_CONTROL; // [RULE_03]
			soft_reset_reg    <= 1'b0;
		end else begin
			soft_reset_reg <= 1'b0;
			if (acc_wr) begin
				case (acc_addr_ptr)
					`ADDR_MEASURE:       measure_reg <= acc_wdata;
					`ADDR_POWER_CONTROL: power_control_reg <= acc_wdata & `PC_WRITE_MASK;
					`ADDR_SOFT_RESET:
						if (acc_wdata == `SOFT_RESET_CODE)
							soft_reset_reg <= 1'b1; // [RULE_13] [RULE_20]
					default:             measure_reg <= measure_reg;
				endcase
			end
		end
	end

	// self test sequence
	always @(posedge mclk) begin
		if (rst_all) begin
			st_state_reg    <= ST_IDLE;
			st_count_reg    <= 8'h00;
			st_finished_reg <= 1'b0;
			selfcheck_run   <= 1'b0;
		end else begin
			if (acc_wr && acc_addr_ptr == `ADDR_SELFCHECK && !acc_wdata[`SC_TRIGGER]) begin
				st_state_reg    <= ST_IDLE; // [RULE_12]
				st_finished_reg <= 1'b0;
				selfcheck_run   <= 1'b0;
				st_count_reg    <= 8'h00;
			end else begin
				case (st_state_reg)
					ST_IDLE:
						if (acc_wr && acc_addr_ptr == `ADDR_SELFCHECK) begin
							st_state_reg  <= ST_RUN; // [RULE_11]
							selfcheck_run <= 1'b1;
							st_count_reg  <= 8'h00;
						end
					ST_RUN: begin
						st_count_reg <= st_count_reg + 8'h01;
						if (st_count_reg == `SELFCHECK_CYCLES - 1) begin
							st_state_reg    <= SELFCHECK_FINISHED;
							st_finished_reg <= 1'b1; // [RULE_12]
						end
					end
					SELFCHECK_FINISHED:
						st_finished_reg <= 1'b1;
					default:
						st_state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// filter settling: restarts on any power control write
	always @(posedge mclk) begin
		if (rst_all || mode_change) begin
			settle_count_reg <= 32'h0000_0000;
			odr_count_reg    <= 3'h0;
			data_valid       <= 1'b0;
		end else if (power_control_reg[1:0] == `MODE_STANDBY) begin
			data_valid <= 1'b0;
		end else if (!data_valid) begin
			if (power_control_reg[`PC_SETTLE_SEL]) begin
				if (odr_tick)
					odr_count_reg <= odr_count_reg + 3'h1;
				if (odr_tick && odr_count_reg == `SETTLE_SHORT_ODRS - 1)
					data_valid <= 1'b1; // [RULE_07]
			end else begin
				settle_count_reg <= settle_count_reg + 32'h0000_0001;
				if (settle_count_reg == SETTLE_LONG_CYCLES - 1)
					data_valid <= 1'b1; // [RULE_06]
			end
		end
	end

	// decoded control outputs
	always @(posedge mclk) begin
		if (rst_all) begin
			bandwidth_code     <= 3'b000;
			bandwidth_hz       <= 12'd160;
			op_mode            <= `MODE_STANDBY;
			measure_active     <= 1'b0;
			instant_on_active  <= 1'b0;
			wakeup_active      <= 1'b0;
			fast_serial_select <= 1'b0;
			wake_level_select  <= 1'b0;
			lowpass_bypass     <= 1'b0;
			highpass_bypass    <= 1'b0;
			device_reset       <= 1'b1;
		end else begin
			bandwidth_code     <= measure_reg[2:0];
			bandwidth_hz       <= bw_hz(measure_reg[2:0]); // [RULE_01] [RULE_02]
			op_mode            <= power_control_reg[1:0];
			measure_active     <= power_control_reg[1:0] == `MODE_MEASURE; // [RULE_10]
			instant_on_active  <= power_control_reg[1:0] == `MODE_INSTANT_ON; // [RULE_10]
			wakeup_active      <= power_control_reg[1:0] == `MODE_WAKEUP; // [RULE_10]
			fast_serial_select <= power_control_reg[`PC_FAST_SERIAL]; // [RULE_04]
			wake_level_select  <= power_control_reg[`PC_WAKE_LEVEL]; // [RULE_05]
			lowpass_bypass     <= power_control_reg[`PC_LOWPASS_BYP]; // [RULE_08]
			highpass_bypass    <= power_control_reg[`PC_HIGHPASS_BYP]; // [RULE_09]
			device_reset       <= 1'b0;
		end
	end
endmodule

// file: accel_power_selftest_fifo_regs_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module regs_checker (
	input wire        mclk,
	input wire        reset,
	input wire        acc_start,
	input wire [7:0]  acc_addr,
	input wire        acc_wr,
	input wire [7:0]  acc_wdata,
	input wire        acc_rd,
	input wire [7:0]  acc_rdata,
	input wire [7:0]  acc_addr_ptr,
	input wire [2:0]  bandwidth_code,
	input wire [11:0] bandwidth_hz,
	input wire        fast_serial_select,
	input wire        lowpass_bypass,
	input wire        selfcheck_run,
	input wire        device_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	reg        direct_reg;
	reg [11:0] hz_exp;
	// pointer reached the queue port by an explicit start
	always @(posedge mclk) begin
		if (reset)
			direct_reg <= 1'b0;
		else if (acc_start)
			direct_reg <= (acc_addr == 8'h42);
	end
	always @* begin
		case (bandwidth_code)
			3'h1: hz_exp = 12'h140;
			3'h2: hz_exp = 12'h280;
			3'h3: hz_exp = 12'h500;
			3'h4: hz_exp = 12'ha00;
			default: hz_exp = 12'h0a0;
		endcase
	end
	a_reset_clears: assert property (disable iff (1'b0)
		reset |=> device_reset && acc_rdata == 8'h00) else $error("reset left state");
	a_bw_map: assert property ($stable(bandwidth_code) |-> bandwidth_hz == hz_exp)
		else $error("bandwidth code gave wrong rate");
	a_queue_fixed: assert property (acc_rd && !acc_start && direct_reg &&
		acc_addr_ptr == 8'h42 |=> acc_addr_ptr == 8'h42) else $error("queue pointer moved");
	a_incr_skip: assert property (acc_rd && !acc_start && !direct_reg &&
		acc_addr_ptr == 8'h42 |=> acc_addr_ptr == 8'h43 && acc_rdata == 8'h00)
		else $error("incremented queue read misbehaved");
	a_reserved_zero: assert property (acc_rd && !acc_start && acc_addr_ptr == 8'h40
		|=> acc_rdata[7:2] == 6'h00) else $error("reserved bits not zero");
	a_power_bits: assert property (acc_wr && !acc_start && acc_addr_ptr == 8'h3f
		|-> ##2 fast_serial_select == $past(acc_wdata[7], 2) && lowpass_bypass == $past(acc_wdata[3], 2))
		else $error("power bits not applied");
	a_selfcheck_go: assert property (acc_wr && !acc_start && acc_addr_ptr == 8'h40
		&& acc_wdata[0] |-> ##[1:2] selfcheck_run) else $error("self test did not start");
	a_soft_reset: assert property (acc_wr && !acc_start && acc_addr_ptr == 8'h41
		&& acc_wdata == 8'h52 |-> ##[1:2] device_reset) else $error("soft reset missing");
endmodule
bind accel_power_selftest_fifo_regs regs_checker chk (.mclk(mclk), .reset(reset),
	.acc_start(acc_start), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
	.acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_addr_ptr(acc_addr_ptr),
	.bandwidth_code(bandwidth_code), .bandwidth_hz(bandwidth_hz), .device_reset(device_reset),
	.fast_serial_select(fast_serial_select), .lowpass_bypass(lowpass_bypass),
	.selfcheck_run(selfcheck_run));

// file: accel_power_selftest_fifo_regs_tb_top.sv
// self-checking bench for the upper register bank
`timescale 1ns/1ps
module accel_power_selftest_fifo_regs_tb_top;
	reg         mclk;
	reg         reset;
	reg         odr_tick;
	reg         sample_push;
	reg  [15:0] sample_data;
	wire [7:0]  acc_rdata, acc_addr_ptr, acc_addr, acc_wdata;
	wire [2:0]  bandwidth_code;
	wire [11:0] bandwidth_hz;
	wire [1:0]  op_mode;
	wire        acc_start, acc_wr, acc_rd, measure_active, instant_on_active, wakeup_active;
	wire        fast_serial_select, wake_level_select, lowpass_bypass, highpass_bypass;
	wire        data_valid, selfcheck_run, device_reset;
	wire [5:0]  pc_bits = {fast_serial_select, wake_level_select, lowpass_bypass,
		highpass_bypass, op_mode};
	integer     err_total, n_checks, i, k;
	reg  [8:0]  q[$];
	reg  [8:0]  e;
	reg  [7:0]  v, x;
	reg  [15:0] s[0:2];
	accel_power_selftest_fifo_regs #(.SETTLE_LONG_CYCLES(200)) uut (
		.mclk               (mclk),
		.reset              (reset),
		.odr_tick           (odr_tick),
		.sample_push        (sample_push),
		.sample_data        (sample_data),
		.acc_start          (acc_start),
		.acc_addr           (acc_addr),
		.acc_wr             (acc_wr),
		.acc_wdata          (acc_wdata),
		.acc_rd             (acc_rd),
		.acc_rdata          (acc_rdata),
		.acc_addr_ptr       (acc_addr_ptr),
		.bandwidth_code     (bandwidth_code),
		.bandwidth_hz       (bandwidth_hz),
		.op_mode            (op_mode),
		.measure_active     (measure_active),
		.instant_on_active  (instant_on_active),
		.wakeup_active      (wakeup_active),
		.fast_serial_select (fast_serial_select),
		.wake_level_select  (wake_level_select),
		.lowpass_bypass     (lowpass_bypass),
		.highpass_bypass    (highpass_bypass),
		.data_valid         (data_valid),
		.selfcheck_run      (selfcheck_run),
		.device_reset       (device_reset)
	);
	host_model h (
		.mclk      (mclk),
		.acc_rdata (acc_rdata),
		.acc_start (acc_start),
		.acc_addr  (acc_addr),
		.acc_wr    (acc_wr),
		.acc_wdata (acc_wdata),
		.acc_rd    (acc_rd)
	);
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk_port(input [15:0] g, input [15:0] w);
		n_checks = n_checks + 1;
		if (g !== w) begin
			err_total = err_total + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, w);
		end
	endtask
	task chk_byte(input [7:0] g, input [7:0] w);
		chk_port({8'h00, g}, {8'h00, w});
	endtask
	// expected byte noted, bit 8 marks a byte that is not compared
	task rdx(input [8:0] w);
		q.push_back(w);
		h.rd;
	endtask
	task wait_valid(input integer lim);
		for (k = 0; k < lim && data_valid !== 1'b1; k = k + 1)
			@(negedge mclk);
		if (k == lim) begin
			err_total = err_total + 1;
			stop_test;
		end
	endtask
	always @(h.got) begin
		e = q.pop_front();
		if (!e[8])
			chk_byte(h.rd_byte, e[7:0]);
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		odr_tick = 1'b0;
		forever begin
			repeat (9) @(negedge mclk);
			odr_tick = 1'b1;
			@(negedge mclk);
			odr_tick = 1'b0;
		end
	end
	initial begin
		err_total = 0;
		n_checks = 0;
		reset = 1'b1;
		sample_push = 1'b0;
		sample_data = 16'h0000;
		v = $urandom(32'h1aae);
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		for (i = 0; i < 2; i = i + 1) begin
			h.start(8'h3f + i[7:0]);
			rdx(9'h000);
		end
		for (i = 0; i < 6; i = i + 1) begin
			h.start(8'h3e);
			h.wr(i[7:0]);
			@(negedge mclk);
			chk_port(bandwidth_hz, (i == 5) ? 16'h00a0 : 16'h00a0 << i);
		end
		for (i = 0; i < 4; i = i + 1) begin
			v = {6'($urandom), i[1:0]};
			h.start(8'h3f);
			h.wr(v);
			@(negedge mclk);
			chk_port(pc_bits, {v[7], v[5], v[3:0]});
			chk_port({measure_active, instant_on_active, wakeup_active}, {i == 3, i == 2, i == 1});
			h.start(8'h3f);
			rdx({1'b0, v & 8'hbf});
		end
		for (i = 0; i < 2; i = i + 1) begin
			h.start(8'h3f);
			h.wr(i ? 8'h13 : 8'h03);
			repeat (i ? 25 : 150) @(negedge mclk);
			chk_port(data_valid, 16'h0000);
			wait_valid(i ? 40 : 120);
		end
		h.start(8'h40);
		h.wr(8'h01);
		@(negedge mclk);
		chk_port(selfcheck_run, 16'h0001);
		repeat (70) @(negedge mclk);
		h.start(8'h40);
		rdx(9'h003);
		h.start(8'h40);
		h.wr(8'h00);
		h.start(8'h40);
		rdx(9'h000);
		for (i = 0; i < 3; i = i + 1) begin
			s[i] = 16'($urandom);
			@(negedge mclk);
			sample_push = 1'b1;
			sample_data = s[i];
			@(negedge mclk);
			sample_push = 1'b0;
		end
		h.start(8'h42);
		for (i = 0; i < 6; i = i + 1) begin
			x = (i % 3 == 1) ? s[i / 3][15:8] : s[i / 3][7:0];
			rdx({1'b0, (i % 3 == 0) ? 8'h00 : x});
		end
		h.start(8'h41);
		rdx(9'h100);
		rdx(9'h000);
		chk_port(acc_addr_ptr, 16'h0043);
		h.start(8'h42);
		rdx(9'h000);
		rdx({1'b0, s[2][15:8]});
		h.start(8'h3f);
		h.wr(8'h84);
		h.start(8'h41);
		h.wr(8'h51);
		h.start(8'h3f);
		rdx(9'h084);
		h.start(8'h41);
		h.wr(8'h52);
		repeat (3) @(negedge mclk);
		h.start(8'h3f);
		rdx(9'h000);
		@(negedge mclk);
		stop_test;
	end
endmodule

// file: accel_regs_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef ACCEL_REGS_MAP_VH
`define ACCEL_REGS_MAP_VH

`define ADDR_MEASURE        8'h3e
`define ADDR_POWER_CONTROL  8'h3f
`define ADDR_SELFCHECK      8'h40
`define ADDR_SOFT_RESET     8'h41
`define ADDR_QUEUE_READ     8'h42

`define RST_POWER_CONTROL   8'h00
`define RST_SELFCHECK       8'h00
`define RST_MEASURE         8'h00
`define SOFT_RESET_CODE     8'h52

`define PC_FAST_SERIAL      7
`define PC_WAKE_LEVEL       5
`define PC_SETTLE_SEL       4
`define PC_LOWPASS_BYP      3
`define PC_HIGHPASS_BYP     2
`define PC_MODE_HI          1
`define PC_MODE_LO          0
`define PC_WRITE_MASK       8'hbf

`define SC_TRIGGER          0
`define SC_FINISHED         1

`define MODE_STANDBY        2'b00
`define MODE_WAKEUP         2'b01
`define MODE_INSTANT_ON     2'b10
`define MODE_MEASURE        2'b11

`define BW_160              3'b000
`define BW_320              3'b001
`define BW_640              3'b010
`define BW_1280             3'b011
`define BW_2560             3'b100

`define CLK_PERIOD_PS       10000
`define SETTLE_LONG_US      462500
`define SETTLE_LONG_CYCLES  ((`SETTLE_LONG_US * 1000) / (`CLK_PERIOD_PS / 1000))
`define SETTLE_SHORT_ODRS   4
`define SELFCHECK_CYCLES    64

`endif

// file: host_model.sv
// host side model: access strobes out, read bytes captured
`timescale 1ns/1ps
module host_model (
	input  wire       mclk,
	input  wire [7:0] acc_rdata,
	output reg        acc_start,
	output reg  [7:0] acc_addr,
	output reg        acc_wr,
	output reg  [7:0] acc_wdata,
	output reg        acc_rd
);
	reg [7:0] rd_byte;
	event     got;
	initial begin
		acc_start = 1'b0;
		acc_addr = 8'h00;
		acc_wr = 1'b0;
		acc_wdata = 8'h00;
		acc_rd = 1'b0;
	end
	// released lines show the inverse of their last value
	task start(input [7:0] a);
		@(negedge mclk);
		acc_start = 1'b1;
		acc_addr = a;
		@(negedge mclk);
		acc_start = 1'b0;
		acc_addr = ~a;
	endtask
	task wr(input [7:0] d);
		@(negedge mclk);
		acc_wr = 1'b1;
		acc_wdata = d;
		@(negedge mclk);
		acc_wr = 1'b0;
		acc_wdata = ~d;
	endtask
	// one idle cycle always follows each read
	task rd;
		@(negedge mclk);
		acc_rd = 1'b1;
		@(negedge mclk);
		acc_rd = 1'b0;
		rd_byte = acc_rdata;
		->got;
	endtask
endmodule

// file: sample_queue.v
// small sample queue with registered read data
`timescale 1ns/1ps
module sample_queue (
	input  wire        mclk,
	input  wire        reset,
	input  wire        push,
	input  wire [15:0] push_data,
	input  wire        pop,
	output reg  [15:0] head_data,
	output reg         empty
);
	reg [15:0] mem [0:31];
	reg [4:0]  wr_ptr_reg;
	reg [4:0]  rd_ptr_reg;
	reg [5:0]  count_reg;
	wire       do_pop;
	wire       do_push;

	assign do_pop  = pop && (count_reg != 6'h00);
	assign do_push = push && ((count_reg != 6'h20) || do_pop);

	always @(posedge mclk) begin
		if (do_push)
			mem[wr_ptr_reg] <= push_data;
	end

	always @(posedge mclk) begin
		if (reset) begin
			wr_ptr_reg <= 5'h00;
			rd_ptr_reg <= 5'h00;
			count_reg  <= 6'h00;
			head_data  <= 16'h0000;
			empty      <= 1'b1;
		end else begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 5'h01;
			if (do_pop) begin
				head_data  <= mem[rd_ptr_reg];
				rd_ptr_reg <= rd_ptr_reg + 5'h01;
			end
			if (do_push && !do_pop)
				count_reg <= count_reg + 6'h01;
			else if (do_pop && !do_push)
				count_reg <= count_reg - 6'h01;
			empty <= ((count_reg == 6'h01) && do_pop && !do_push) ||
				((count_reg == 6'h00) && !do_push);
		end
	end
endmodule
